// ---- bench/rdm_mem_model.sv ----
`timescale 1ns/1ps
module rdm_mem_model (
    input wire logic mclk, rst_n, memReq, memWe, // Clock, reset, access
    input wire logic [31:0] memAddr, memWdata, // Address, write data
    input wire logic [3:0] lat, // Answer delay in cycles
    output logic memAck, // Access done
    output logic [31:0] memRdata // Read data
);
    logic [31:0] mem [0:255];
    logic [3:0] cnt;
    // Descriptor words at desc, +4, +8, status at +0xc
    always @(posedge mclk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata; // Not valid outside ack
        if (!rst_n) memRdata <= 32'h0;
        if (!rst_n || !memReq || memAck) begin
            cnt <= 4'h0;
        end else if (cnt == lat) begin
            memAck <= 1'b1;
            if (memWe) mem[memAddr[9:2]] <= memWdata;
            else memRdata <= mem[memAddr[9:2]];
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // rdm_mem_model

// ---- bench/rdm_props.sv ----
`timescale 1ns/1ps
`include "rdm_defs.svh"
module rdm_props (
    input wire logic mclk, rst_n, psel, penable, pready, pslverr,
    input wire logic memReq, memAck, rbDataReady, rbReqReady,
    input wire logic [31:0] memAddr,
    input wire logic vecValid, vecReady,
    input wire rdm_pkg::rdm_vec_type vecOut
);
    import rdm_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ready_once_a: assert property (pready |=> !pready)
        else $error("pready held");
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    mem_hold_a: assert property (memReq && !memAck |=>
        memReq && $stable(memAddr)) else $error("memory request dropped");
    word_align_a: assert property (memReq |-> memAddr[1:0] == 2'h0)
        else $error("unaligned memory access");
    vec_hold_a: assert property (vecValid && !vecReady |=>
        vecValid && $stable(vecOut)) else $error("vector dropped");
    silent_bits_a: assert property (vecValid &&
        vecOut.vtype == `RDM_V_SILENT |-> vecOut.hold_abort_indicator && vecOut.receive_abort_flag)
        else $error("silent vector flags");
    word_pulse_a: assert property (rbDataReady |=> !rbDataReady)
        else $error("word ready held");
    req_pulse_a: assert property (rbReqReady |=> !rbReqReady)
        else $error("request ready held");
endmodule // rdm_props
bind rdm_rx_dma rdm_props props (.*);

// ---- bench/rdm_rx_dma_tb.sv ----
`timescale 1ns/1ps
`include "rdm_defs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("Error at %0t got %h exp %h", $time, a, e); end end
module rdm_rx_dma_tb;
    import rdm_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rbData = 32'h0, rd, prdata;
    logic [31:0] memAddr, memWdata, memRdata;
    logic pready, pslverr, rbReqValid = 0, rbReqReady, rbDataValid = 0;
    logic rbDataReady, memReq, memWe, memAck, vecValid, vecReady = 0;
    logic [3:0] lat = 4'h0;
    rdm_req_type rbReq = '0;
    rdm_vec_type vecOut;
    int fail_count = 0, check_count = 0;
    rdm_rx_dma dut (.*);
    rdm_mem_model m (.*);
    initial forever #5 mclk = ~mclk;
    // One APB transfer, waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk) penable <= 1;
        do @(posedge mclk); while (!pready);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
        @(posedge mclk);
    endtask
    // Request of two words on channel 5
    task send(input logic [15:0] n, input logic eof, input logic [31:0] a);
        rbReq <= '{chan: 8'h05, len: n, eof: eof, err: 5'h00};
        rbReqValid <= 1;
        do @(posedge mclk); while (!rbReqReady);
        rbReqValid <= 0; rbDataValid <= 1; rbData <= a;
        do @(posedge mclk); while (!rbDataReady);
        rbData <= ~a;
        do @(posedge mclk); while (!rbDataReady);
        rbDataValid <= 0; rbData <= a;
    endtask
    task vec(input logic [1:0] t, input logic [5:0] g);
        do @(posedge mclk); while (!vecValid);
        `CHK({vecOut.queue, vecOut.chan, vecOut.vtype, vecOut.tag},
            {5'h03, 8'h05, t, g})
        vecReady <= 1;
        @(posedge mclk) vecReady <= 0;
    endtask
    task regs_test;
        apb(1, `RDM_A_CFGADR, 32'h40);
        apb(1, `RDM_A_CFG, 32'h0100_00c1);
        apb(1, `RDM_A_CMD, {21'h0, `RDM_OP_INIT, 8'h05});
        apb(0, 8'h20, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        $display("regs test done");
    endtask
    task frame_test;
        send(16'h8, 1, 32'h1122_3344);
        vec(`RDM_V_FE, 6'h2a);
        vec(`RDM_V_RHI, 6'h2a);
        do apb(0, `RDM_A_STAT, 0); while (rd[1:0] != 2'h0);
        `CHK(m.mem[8'h13], 32'hc000_0008)
        `CHK({m.mem[8'h40], m.mem[8'h41]}, 64'h1122_3344_eedd_ccbb)
        $display("frame test done");
    endtask
    task hold_test;
        lat <= 4'h3;
        // Vector comes mid-request, so accept it alongside the data
        fork
            send(16'h8, 0, 32'h5a5a_0f0f);
            vec(`RDM_V_HABT, 6'h15);
        join
        do apb(0, `RDM_A_STAT, 0); while (rd[1:0] != 2'h0);
        `CHK(m.mem[8'h23], 32'hc001_0004)
        `CHK(m.mem[8'h50], 32'h5a5a_0f0f)
        $display("hold test done");
    endtask
    // Held channel discards, then abort branches to a fresh list
    task abort_test;
        send(16'h8, 1, 32'h0);
        send(16'h8, 1, 32'h0);
        vec(`RDM_V_SILENT, 6'h15);
        apb(1, `RDM_A_FRDA, 32'hc0);
        apb(1, `RDM_A_CMD, {21'h0, `RDM_OP_ABORT, 8'h05});
        send(16'h8, 1, 32'h0102_0304);
        vec(`RDM_V_FE, 6'h31);
        `CHK(m.mem[8'h33], 32'hc000_0008)
        `CHK({m.mem[8'h61], m.mem[8'h62]}, 64'h0102_0304_fefd_fcfb)
        $display("abort test done");
    endtask
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Descriptors: first with host vector, second held
    initial begin
        m.mem[8'h10] = 32'h202a_0008;
        m.mem[8'h11] = 32'h80;
        m.mem[8'h12] = 32'h100;
        m.mem[8'h20] = 32'h4015_0004;
        m.mem[8'h21] = 32'hc0;
        m.mem[8'h22] = 32'h140;
        m.mem[8'h30] = 32'h0431_000c;
        m.mem[8'h32] = 32'h180;
        repeat (20) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        regs_test();
        frame_test();
        hold_test();
        abort_test();
        finish_test();
    end
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule // rdm_rx_dma_tb

// ---- hw/rdm_defs.svh ----
`ifndef RDM_DEFS_SVH
`define RDM_DEFS_SVH

// Register byte offsets on the APB slave
`define RDM_A_CMD 8'h00
`define RDM_A_FRDA 8'h04
`define RDM_A_CFGADR 8'h08
`define RDM_A_CFG 8'h0c
`define RDM_A_STAT 8'h10

// Command opcodes, CMD register bits 10:8
`define RDM_OP_INIT 3'h1
`define RDM_OP_ABORT 3'h2
`define RDM_OP_HRST 3'h3
`define RDM_OP_OFF 3'h4

// Descriptor word offsets
`define RDM_DW_LINK 32'h4
`define RDM_DW_SECT 32'h8
`define RDM_DW_STAT 32'hc

// Descriptor word 0 and status word bits
`define RDM_D0_HOLD 30
`define RDM_D0_RHI 29
`define RDM_ST_FE 31
`define RDM_ST_C 30

// Vector type codes, also mask bit positions
`define RDM_V_FE 2'h0
`define RDM_V_RHI 2'h1
`define RDM_V_HABT 2'h2
`define RDM_V_SILENT 2'h3

`define RDM_MODE_TRANSP 2'h0
`define RDM_WORD_BYTES 16'h4
`define RDM_CHANNELS 256

`endif

// ---- hw/rdm_pkg.sv ----
package rdm_pkg;
    typedef enum {
        S_IDLE, S_LOAD, S_CMD, S_CMDX, S_CMDEND, S_DECIDE, S_FETCH, S_POLL,
        S_POLLX, S_GET, S_WR, S_WDONE, S_STAT, S_VEC, S_SAVE
    } rdm_state_type;

    // Request from the receive buffer; err is {mfl,receive_overflow_flag,crc,illegal_length_flag,rab}
    typedef struct packed {
        logic [7:0] chan;
        logic [15:0] len;
        logic eof;
        logic [4:0] err;
    } rdm_req_type;

    typedef struct packed {
        logic [4:0] queue;
        logic [7:0] chan;
        logic [1:0] vtype;
        logic [5:0] tag;
        logic hold_abort_indicator;
        logic receive_abort_flag;
    } rdm_vec_type;

    typedef struct packed {
        logic [31:0] descAddr;
        logic [31:0] link;
        logic [31:0] sect;
        logic [15:0] size;
        logic [15:0] filled;
        logic [16:0] frameLen;
        logic [15:0] maxLen;
        logic [4:0] secOff;
        logic [2:0] off;
        logic [5:0] tag;
        logic [1:0] mode;
        logic [3:0] mask;
        logic [4:0] queue;
        logic loaded, hold, host_requested_rx_interrupt, inFrame, needPoll, abortOnHold;
        logic poll, hrPend, waitStart, discardFrame;
    } rdm_chan_type;
endpackage

// ---- hw/rdm_rx_dma.sv ----
`timescale 1ns/1ps
`include "rdm_defs.svh"

module rdm_rx_dma (
    input wire logic mclk,                  // 100 MHz clock
    input wire logic rst_n,                 // Sync reset, active low
    input wire logic psel,                  // APB select
    input wire logic penable,               // APB enable
    input wire logic pwrite,                // APB direction
    input wire logic [7:0] paddr,           // APB byte address
    input wire logic [31:0] pwdata,         // APB write data
    output logic [31:0] prdata,             // APB read data
    output logic pready,                    // APB ready
    output logic pslverr,                   // APB error
    input wire logic rbReqValid,            // Buffer request valid
    input wire rdm_pkg::rdm_req_type rbReq, // Buffer request
    output logic rbReqReady,                // Request taken pulse
    input wire logic rbDataValid,           // Buffer word valid
    input wire logic [31:0] rbData,         // Buffer word
    output logic rbDataReady,               // Word taken pulse
    output logic memReq,                    // Memory access request
    output logic memWe,                     // Memory write
    output logic [31:0] memAddr,            // Memory byte address
    output logic [31:0] memWdata,           // Memory write data
    input wire logic memAck,                // Memory access done
    input wire logic [31:0] memRdata,       // Memory read data
    output logic vecValid,                  // Interrupt vector valid
    output rdm_pkg::rdm_vec_type vecOut,    // Interrupt vector
    input wire logic vecReady               // Vector accepted
);
    import rdm_pkg::*;

    rdm_state_type state, retState;
    rdm_chan_type db [`RDM_CHANNELS];
    rdm_chan_type cur;
    rdm_req_type req;
    logic [`RDM_CHANNELS-1:0] chanActive;
    logic [7:0] chan;
    logic [15:0] lenLeft;
    logic [1:0] idx;
    logic [31:0] wordBuf, statWord, statAddr;
    logic [3:0] vecPend;
    logic disc, dead, midFill;
    logic cmdPend, cmdTake;
    logic [2:0] cmdOp;
    logic [7:0] cmdChan;
    logic [31:0] frda, cfgAddr, cfg;
    logic [15:0] space, wb;
    logic last, mflHit;

    // Status word: FE, C, five flags, byte count
    function automatic logic [31:0] mkStat(input logic fe, input logic c,
                                           input logic [4:0] err,
                                           input logic [15:0] received_byte_count);
        logic [31:0] w;
        w = 32'h0;
        w[`RDM_ST_FE] = fe;
        w[`RDM_ST_C] = c;
        w[20:16] = err;
        w[15:0] = received_byte_count;
        return w;
    endfunction

    // Section space and bytes carried by the current word
    always_comb begin
        space = cur.size - 16'(cur.secOff) - cur.filled;
        wb = (lenLeft > `RDM_WORD_BYTES) ? `RDM_WORD_BYTES : lenLeft;
        last = (lenLeft == wb);
        mflHit = (cur.frameLen + 17'(wb)) > {1'b0, cur.maxLen};
    end

    // APB slave, one wait-free access phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            frda <= 32'h0;
            cfgAddr <= 32'h0;
            cfg <= 32'h0;
            cmdPend <= 1'b0;
            cmdOp <= 3'h0;
            cmdChan <= 8'h0;
        end else begin
            pready <= psel && !penable;
            // Error flag stands only with its ready cycle
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0;
                case (paddr)
                    `RDM_A_CMD: pslverr <= pwrite && cmdPend;
                    `RDM_A_FRDA: prdata <= frda;
                    `RDM_A_CFGADR: prdata <= cfgAddr;
                    `RDM_A_CFG: prdata <= cfg;
                    `RDM_A_STAT: begin
                        prdata <= {16'h0, chan, 6'h0, cmdPend,
                                   state != S_IDLE};
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
            if (cmdTake) begin
                cmdPend <= 1'b0;
            end
            if (psel && penable && pready && pwrite && !pslverr) begin
                case (paddr)
                    `RDM_A_CMD: begin
                        cmdPend <= 1'b1;
                        cmdChan <= pwdata[7:0];
                        cmdOp <= pwdata[10:8];
                    end
                    `RDM_A_FRDA: frda <= {pwdata[31:2], 2'b00};
                    `RDM_A_CFGADR: cfgAddr <= {pwdata[31:2], 2'b00};
                    `RDM_A_CFG: cfg <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // Channel database write-back
    always_ff @(posedge mclk) begin
        if (state == S_SAVE) begin
            db[chan] <= cur;
        end
    end

    // Descriptor, data and vector sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            retState <= S_IDLE;
            rbReqReady <= 1'b0;
            rbDataReady <= 1'b0;
            memReq <= 1'b0;
            memWe <= 1'b0;
            memAddr <= 32'h0;
            memWdata <= 32'h0;
            vecValid <= 1'b0;
            vecOut <= '0;
            cmdTake <= 1'b0;
            chanActive <= '0;
            cur <= '0;
            req <= '0;
            chan <= 8'h0;
            lenLeft <= 16'h0;
            idx <= 2'h0;
            wordBuf <= 32'h0;
            statWord <= 32'h0;
            statAddr <= 32'h0;
            vecPend <= 4'h0;
            disc <= 1'b0;
            dead <= 1'b0;
            midFill <= 1'b0;
        end else begin
            rbReqReady <= 1'b0;
            rbDataReady <= 1'b0;
            cmdTake <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (cmdPend && !cmdTake) begin
                        cmdTake <= 1'b1;
                        chan <= cmdChan;
                        state <= S_CMD;
                    end else if (rbReqValid && !rbReqReady) begin
                        rbReqReady <= 1'b1;
                        req <= rbReq;
                        chan <= rbReq.chan;
                        lenLeft <= rbReq.len;
                        state <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    cur <= db[chan];
                    dead <= !chanActive[chan];
                    state <= S_DECIDE;
                end
                S_CMD: begin
                    cur <= db[chan];
                    state <= S_CMDX;
                end
                S_CMDX: begin
                    state <= S_SAVE;
                    if (cmdOp == `RDM_OP_INIT) begin
                        cur <= '0;
                        cur.descAddr <= cfgAddr;
                        cur.mode <= cfg[1:0];
                        cur.mask <= cfg[5:2];
                        cur.queue <= cfg[10:6];
                        cur.maxLen <= cfg[31:16];
                        chanActive[chan] <= 1'b1;
                    end else if (!chanActive[chan]) begin
                        state <= S_IDLE;
                    end else if (cmdOp == `RDM_OP_HRST) begin
                        cur.hrPend <= cur.poll;
                    end else if (cmdOp == `RDM_OP_ABORT ||
                                 cmdOp == `RDM_OP_OFF) begin
                        state <= S_CMDEND;
                        if (cur.loaded && !cur.needPoll && !cur.poll) begin
                            statWord <= mkStat(
                                cur.mode != `RDM_MODE_TRANSP, 1'b1,
                                {4'h0, cur.inFrame}, cur.filled);
                            memReq <= 1'b1;
                            memWe <= 1'b1;
                            memAddr <= cur.descAddr + `RDM_DW_STAT;
                            memWdata <= mkStat(
                                cur.mode != `RDM_MODE_TRANSP, 1'b1,
                                {4'h0, cur.inFrame}, cur.filled);
                            vecPend <= 4'h0;
                            retState <= S_CMDEND;
                            state <= S_STAT;
                        end
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_CMDEND: begin
                    cur.loaded <= 1'b0;
                    cur.inFrame <= 1'b0;
                    cur.frameLen <= 17'h0;
                    cur.needPoll <= 1'b0;
                    cur.abortOnHold <= 1'b0;
                    cur.poll <= 1'b0;
                    cur.hrPend <= 1'b0;
                    cur.waitStart <= 1'b0;
                    cur.discardFrame <= 1'b0;
                    if (cmdOp == `RDM_OP_ABORT) begin
                        cur.descAddr <= frda;
                    end else begin
                        chanActive[chan] <= 1'b0;
                    end
                    state <= S_SAVE;
                end
                S_DECIDE: begin
                    idx <= 2'h0;
                    if (lenLeft == 16'h0) begin
                        state <= S_SAVE;
                    end else if (dead || (cur.poll && !cur.hrPend) ||
                                 cur.waitStart || cur.discardFrame) begin
                        disc <= 1'b1;
                        state <= S_GET;
                    end else if (!cur.loaded) begin
                        memReq <= 1'b1;
                        memWe <= 1'b0;
                        memAddr <= cur.descAddr;
                        state <= S_FETCH;
                    end else if (cur.needPoll || cur.poll || space == 0) begin
                        midFill <= !cur.needPoll && !cur.poll;
                        memReq <= 1'b1;
                        memWe <= 1'b0;
                        memAddr <= cur.descAddr;
                        state <= S_POLL;
                    end else begin
                        disc <= 1'b0;
                        state <= S_GET;
                    end
                end
                S_FETCH: begin
                    if (memReq && memAck) begin
                        memReq <= 1'b0;
                        idx <= idx + 2'h1;
                        if (idx == 2'h0) begin
                            cur.size <= memRdata[15:0];
                            cur.hold <= memRdata[`RDM_D0_HOLD];
                            cur.host_requested_rx_interrupt <= memRdata[`RDM_D0_RHI];
                            cur.off <= memRdata[28:26];
                            cur.tag <= memRdata[21:16];
                        end else if (idx == 2'h1) begin
                            cur.link <= {memRdata[31:2], 2'b00};
                        end else begin
                            cur.sect <= {memRdata[31:2], 2'b00};
                            cur.loaded <= 1'b1;
                            cur.filled <= 16'h0;
                            cur.needPoll <= 1'b0;
                            cur.secOff <= (!cur.inFrame &&
                                cur.mode != `RDM_MODE_TRANSP) ?
                                {cur.off, 2'b00} : 5'h0;
                            state <= S_DECIDE;
                        end
                        if (idx != 2'h2) begin
                            memReq <= 1'b1;
                            memAddr <= memAddr + `RDM_WORD_BYTES;
                        end
                    end
                end
                S_POLL: begin
                    if (memReq && memAck) begin
                        memReq <= 1'b0;
                        idx <= idx + 2'h1;
                        if (idx == 2'h0) begin
                            cur.hold <= memRdata[`RDM_D0_HOLD];
                            memReq <= 1'b1;
                            memAddr <= memAddr + `RDM_DW_LINK;
                        end else begin
                            cur.link <= {memRdata[31:2], 2'b00};
                            state <= S_POLLX;
                        end
                    end
                end
                S_POLLX: begin
                    cur.hrPend <= 1'b0;
                    cur.needPoll <= 1'b0;
                    cur.abortOnHold <= 1'b0;
                    midFill <= 1'b0;
                    vecPend <= 4'h0;
                    retState <= S_DECIDE;
                    state <= S_DECIDE;
                    statAddr <= cur.descAddr + `RDM_DW_STAT;
                    if (!cur.hold) begin
                        cur.loaded <= 1'b0;
                        cur.descAddr <= cur.link;
                        cur.poll <= 1'b0;
                        cur.waitStart <= cur.poll && cur.inFrame &&
                            cur.mode != `RDM_MODE_TRANSP;
                        if (midFill) begin
                            statWord <= mkStat(1'b0, 1'b1, 5'h0,
                                               cur.filled);
                            vecPend[`RDM_V_RHI] <= cur.host_requested_rx_interrupt;
                            state <= S_STAT;
                        end
                    end else if (!cur.poll) begin
                        cur.poll <= 1'b1;
                        if (midFill) begin
                            statWord <= mkStat(1'b1, 1'b1, 5'h1,
                                               cur.filled);
                            vecPend[`RDM_V_HABT] <= 1'b1;
                            cur.discardFrame <= 1'b1;
                            state <= S_STAT;
                        end else if (cur.abortOnHold && cur.inFrame) begin
                            vecPend[`RDM_V_HABT] <= 1'b1;
                            cur.discardFrame <= 1'b1;
                            state <= S_VEC;
                        end
                    end
                end
                S_GET: begin
                    if (rbDataValid && !rbDataReady) begin
                        rbDataReady <= 1'b1;
                        wordBuf <= rbData;
                        state <= S_WDONE;
                        if (!disc) begin
                            memReq <= 1'b1;
                            memWe <= 1'b1;
                            memAddr <= cur.sect + 32'(cur.secOff) +
                                       32'(cur.filled);
                            memWdata <= rbData;
                            state <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (memReq && memAck) begin
                        memReq <= 1'b0;
                        state <= S_WDONE;
                    end
                end
                S_WDONE: begin
                    lenLeft <= lenLeft - wb;
                    vecPend <= 4'h0;
                    retState <= S_DECIDE;
                    statAddr <= cur.descAddr + `RDM_DW_STAT;
                    state <= S_DECIDE;
                    if (disc) begin
                        if (last && req.eof) begin
                            cur.inFrame <= 1'b0;
                            cur.frameLen <= 17'h0;
                            cur.waitStart <= 1'b0;
                            cur.discardFrame <= 1'b0;
                            if (cur.poll && !cur.discardFrame && !dead) begin
                                vecPend[`RDM_V_SILENT] <= 1'b1;
                                state <= S_VEC;
                            end
                        end else begin
                            cur.inFrame <= 1'b1;
                        end
                    end else begin
                        cur.filled <= cur.filled + wb;
                        cur.frameLen <= cur.frameLen + 17'(wb);
                        cur.inFrame <= !(last && req.eof);
                        if (last && req.eof) begin
                            statWord <= mkStat(1'b1, 1'b1,
                                {req.err[4] | mflHit, req.err[3:0]},
                                cur.filled + wb);
                            vecPend[`RDM_V_FE] <= 1'b1;
                            vecPend[`RDM_V_RHI] <= cur.host_requested_rx_interrupt;
                            cur.needPoll <= 1'b1;
                            cur.frameLen <= 17'h0;
                            state <= S_STAT;
                        end else if (last && space == wb) begin
                            statWord <= mkStat(1'b0, 1'b1, 5'h0,
                                               cur.filled + wb);
                            vecPend[`RDM_V_RHI] <= cur.host_requested_rx_interrupt;
                            cur.needPoll <= 1'b1;
                            cur.abortOnHold <= 1'b1;
                            state <= S_STAT;
                        end
                    end
                end
                S_STAT: begin
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWe <= 1'b1;
                        memAddr <= statAddr;
                        memWdata <= statWord;
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        state <= S_VEC;
                    end
                end
                S_VEC: begin
                    if (vecValid) begin
                        if (vecReady) begin
                            vecValid <= 1'b0;
                        end
                    end else if (vecPend == 4'h0) begin
                        state <= retState;
                    end else begin
                        for (int i = 3; i >= 0; i--) begin
                            if (vecPend[i]) begin
                                idx <= 2'(i);
                            end
                        end
                        vecPend[idx] <= 1'b0;
                        if (vecPend[idx] && !cur.mask[idx]) begin
                            vecValid <= 1'b1;
                            vecOut.queue <= cur.queue;
                            vecOut.chan <= chan;
                            vecOut.vtype <= idx;
                            vecOut.tag <= cur.tag;
                            vecOut.hold_abort_indicator <= idx == `RDM_V_SILENT;
                            vecOut.receive_abort_flag <= idx >= `RDM_V_HABT;
                        end
                    end
                end
                S_SAVE: begin
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // rdm_rx_dma
